// ---- design/dosc_device.sv ----
// Converter control end: serial register file, offset adders, temperature
// result, sleep, gain and reference controls.
// Assumes serial pins come from another domain and are resynchronised here.
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module dosc_device import dosc_pkg::*; #(
  parameter int SLEEP_CYC = SLEEP_NS / PCLK_NS,
  parameter int SAMPLE_W  = 16,
  parameter int TEMP_W    = 10,
  parameter int TEMP_SHIFT = 1
) (
  // Clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // Link
  dosc_if.dev_mp                          link,
  // Sample paths
  input  wire logic signed [SAMPLE_W-1:0] sample_a,
  input  wire logic signed [SAMPLE_W-1:0] sample_b,
  output logic signed [SAMPLE_W-1:0]      data_a,
  output logic signed [SAMPLE_W-1:0]      data_b,
  // Sensor front end
  input  wire logic signed [TEMP_W-1:0]   temp_raw,
  // Analog controls
  output logic [4:0]                      fs_scale_a,
  output logic [4:0]                      fs_scale_b,
  output logic                            bandgap_on,
  output logic                            dac_asleep_a,
  output logic                            dac_asleep_b,
  output logic                            clkpath_sleep_a,
  output logic                            clkpath_sleep_b,
  output logic                            clkrecv_sleep,
  output logic                            fifo_reset_ena,
  output logic                            multi_sync_ena,
  output logic                            clkdiv_sync_ena,
  output logic                            tx_active
);
  localparam int NS = 5;
  localparam int I_SCLK = 0;
  localparam int I_CSN  = 1;
  localparam int I_SDI  = 2;
  localparam int I_RST  = 3;
  localparam int I_TXE  = 4;
  localparam logic [NS-1:0] LVL_RST = 5'h0A;
  localparam logic signed [SAMPLE_W:0] SMAX = (17'sd1 <<< (SAMPLE_W - 1)) - 17'sd1;
  localparam logic signed [SAMPLE_W:0] SMIN = -(17'sd1 <<< (SAMPLE_W - 1));

  logic [NS-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
  logic [NS-1:0] chg;
  logic          sclk_rise, sclk_fall, soft_rst;
  logic [4:0]    cnt_reg;
  logic [7:0]    hdr_reg, wsh_reg, out_reg;
  logic          sdo_reg, oe_reg;
  logic          wr_en;
  logic [7:0]    wr_data;
  logic [7:0]    rd_mux;
  logic [7:0]    main_reg, sleep_reg, gain_reg, divsyn_reg, tctrl_reg, ref_reg;
  logic [7:0]    stage_reg [4];
  logic signed [12:0] ofs_a_reg, ofs_b_reg;
  logic signed [7:0]  temp_reg;
  logic signed [7:0]  temp_next;
  logic signed [TEMP_W-1:0] temp_scaled;
  logic [31:0]   slp_cnt_reg [2];
  logic [1:0]    asleep_reg;

  // Three-stage capture; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= LVL_RST;
      s2_reg <= LVL_RST;
      s3_reg <= LVL_RST;
    end else begin
      s1_reg <= {link.transmit_enable_pin, link.reset_n_pin, link.sdio,
                 link.serial_select_n, link.sclk};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign chg = ~(s2_reg ^ s3_reg) & (s3_reg ^ lvl_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_reg <= LVL_RST;
    end else begin
      lvl_reg <= lvl_reg ^ chg;
    end
  end

  assign sclk_rise = chg[I_SCLK] & s3_reg[I_SCLK] & ~lvl_reg[I_CSN];
  assign sclk_fall = chg[I_SCLK] & ~s3_reg[I_SCLK] & ~lvl_reg[I_CSN];
  assign soft_rst  = ~lvl_reg[I_RST];
  assign tx_active = lvl_reg[I_TXE];

  // Serial frame: 8 header bits then 8 data bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 5'h00;
      hdr_reg <= 8'h00;
      wsh_reg <= 8'h00;
      out_reg <= 8'h00;
      sdo_reg <= 1'b0;
      oe_reg  <= 1'b0;
    end else if (lvl_reg[I_CSN] || soft_rst) begin
      cnt_reg <= 5'h00;
      oe_reg  <= 1'b0;
    end else if (sclk_rise) begin
      if (cnt_reg < 5'd16) begin
        cnt_reg <= cnt_reg + 5'd1;
      end
      if (cnt_reg < 5'd8) begin
        hdr_reg <= {hdr_reg[6:0], lvl_reg[I_SDI]};
      end else if (hdr_reg[RD_BIT]) begin
        if (cnt_reg == 5'd8) begin
          sdo_reg <= rd_mux[7];
          out_reg <= {rd_mux[6:0], 1'b0};
          oe_reg  <= 1'b1;
        end else begin
          sdo_reg <= out_reg[7];
          out_reg <= {out_reg[6:0], 1'b0};
        end
      end else begin
        wsh_reg <= {wsh_reg[6:0], lvl_reg[I_SDI]};
      end
    end
  end

  assign link.dev_sdo    = sdo_reg;
  assign link.dev_sdo_oe = oe_reg;

  assign wr_en   = sclk_rise && !hdr_reg[RD_BIT] && cnt_reg == 5'd15;
  assign wr_data = {wsh_reg[6:0], lvl_reg[I_SDI]};

  always_comb begin
    unique case (hdr_reg[4:0])
      ADDR_MAIN:   rd_mux = main_reg;
      ADDR_SLEEP:  rd_mux = sleep_reg;
      ADDR_GAIN:   rd_mux = gain_reg;
      ADDR_TEMP:   rd_mux = temp_reg;
      ADDR_DIVSYN: rd_mux = divsyn_reg;
      ADDR_OFS_AL: rd_mux = stage_reg[0];
      ADDR_OFS_AH: rd_mux = stage_reg[1];
      ADDR_OFS_BL: rd_mux = stage_reg[2];
      ADDR_OFS_BH: rd_mux = stage_reg[3];
      ADDR_TCTRL:  rd_mux = tctrl_reg;
      ADDR_REFCTL: rd_mux = ref_reg;
      default:     rd_mux = 8'h00;
    endcase
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_reg   <= MAIN_RST;
      sleep_reg  <= ZERO_RST;
      gain_reg   <= GAIN_RST;
      divsyn_reg <= DIVSYN_RST;
      tctrl_reg  <= ZERO_RST;
      ref_reg    <= ZERO_RST;
    end else if (soft_rst) begin
      main_reg   <= MAIN_RST;
      sleep_reg  <= ZERO_RST;
      gain_reg   <= GAIN_RST;
      divsyn_reg <= DIVSYN_RST;
      tctrl_reg  <= ZERO_RST;
      ref_reg    <= ZERO_RST;
    end else if (wr_en) begin
      unique case (hdr_reg[4:0])
        ADDR_MAIN:   main_reg   <= wr_data;
        ADDR_SLEEP:  sleep_reg  <= wr_data;
        ADDR_GAIN:   gain_reg   <= wr_data;
        ADDR_DIVSYN: divsyn_reg <= wr_data;
        ADDR_TCTRL:  tctrl_reg  <= wr_data;
        ADDR_REFCTL: ref_reg    <= wr_data;
        default: ;
      endcase
    end
  end

  // Staged offsets; only the commit address moves them to the adders
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) stage_reg[i] <= ZERO_RST;
      ofs_a_reg <= 13'sd0;
      ofs_b_reg <= 13'sd0;
    end else if (soft_rst) begin
      for (int i = 0; i < 4; i++) stage_reg[i] <= ZERO_RST;
      ofs_a_reg <= 13'sd0;
      ofs_b_reg <= 13'sd0;
    end else if (wr_en) begin
      unique case (hdr_reg[4:0])
        ADDR_OFS_AL: begin
          stage_reg[0] <= wr_data;
          ofs_a_reg    <= {stage_reg[1][4:0], wr_data};
          ofs_b_reg    <= {stage_reg[3][4:0], stage_reg[2]};
        end
        ADDR_OFS_AH: stage_reg[1] <= {3'b000, wr_data[4:0]};
        ADDR_OFS_BL: stage_reg[2] <= wr_data;
        ADDR_OFS_BH: stage_reg[3] <= {3'b000, wr_data[4:0]};
        default: ;
      endcase
    end
  end

  // Saturating offset adders, LSB aligned
  function automatic logic signed [SAMPLE_W-1:0] dosc_add(
      input logic signed [SAMPLE_W-1:0] s, input logic signed [12:0] o);
    logic signed [SAMPLE_W:0] sum;
    sum = {s[SAMPLE_W-1], s} + {{(SAMPLE_W-12){o[12]}}, o};
    if (sum > SMAX) begin
      sum = SMAX;
    end else if (sum < SMIN) begin
      sum = SMIN;
    end
    return sum[SAMPLE_W-1:0];
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_a <= '0;
      data_b <= '0;
    end else begin
      data_a <= dosc_add(sample_a, ofs_a_reg);
      data_b <= dosc_add(sample_b, ofs_b_reg);
    end
  end

  // Temperature: scaled and limited to signed byte
  always_comb begin
    temp_scaled = temp_raw >>> TEMP_SHIFT;
    if (temp_scaled > 127) begin
      temp_next = 8'sh7F;
    end else if (temp_scaled < -128) begin
      temp_next = 8'sh80;
    end else begin
      temp_next = temp_scaled[7:0];
    end
  end

  // Paced by serial edges only, so sleep bits do not stop it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_reg <= 8'sh00;
    end else if (sclk_fall && cnt_reg == 5'd8 && tctrl_reg[TSENSE_BIT]) begin
      temp_reg <= temp_next;
    end
  end

  // Converter sleep state follows its bit after the settle time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 2; i++) slp_cnt_reg[i] <= 32'h0;
      asleep_reg <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (sleep_reg[SLP_DAC_A + i] == asleep_reg[i]) begin
          slp_cnt_reg[i] <= 32'h0;
        end else if (slp_cnt_reg[i] >= 32'(SLEEP_CYC - 1)) begin
          asleep_reg[i]  <= sleep_reg[SLP_DAC_A + i];
          slp_cnt_reg[i] <= 32'h0;
        end else begin
          slp_cnt_reg[i] <= slp_cnt_reg[i] + 32'h1;
        end
      end
    end
  end

  assign dac_asleep_a    = asleep_reg[0];
  assign dac_asleep_b    = asleep_reg[1];
  assign clkpath_sleep_a = sleep_reg[SLP_CLK_A];
  assign clkpath_sleep_b = sleep_reg[SLP_CLK_B];
  assign clkrecv_sleep   = sleep_reg[SLP_RECV];
  assign fs_scale_a      = {1'b0, gain_reg[7:4]} + 5'd1;
  assign fs_scale_b      = {1'b0, gain_reg[3:0]} + 5'd1;
  assign bandgap_on      = ~ref_reg[EXTREF_BIT];
  assign fifo_reset_ena  = main_reg[MAIN_FIFO_RST_BIT];
  assign multi_sync_ena  = main_reg[MAIN_MSYNC_BIT];
  assign clkdiv_sync_ena = divsyn_reg[DIVSYN_BIT];
endmodule
`default_nettype wire

// ---- include/dosc_pkg.sv ----
// Constants shared by both ends of the converter control link.
// Assumes a 250 MHz pclk on both ends.
// Operation
// - Offsets are 13-bit signed, per path
// - Commit register write loads all four stages
// - Other stage writes leave active offset alone
// - Host writes commit register last
// - Active offset added to each sample
// - Offset and sample aligned at LSB
// - Temperature is 8-bit signed degrees, limited
// - Enabled sensor converts on every access
// - Result sent only on temperature read
// - First eight serial clocks convert; valid eighth fall
// - Result shifted out from ninth rising edge
// - Sensor needs only serial clock, works asleep
// - Host reads temperature with slow serial clock
// - Host start-up order with reset pulse
// - Host clears divider sync after frame rise
// - Host may clear FIFO and multi sync
// - Separate sleep bits, one means asleep
// - Converter sleep entry and exit take 90us
// - Four-bit coarse gain, scale is gain+1
// - Bandgap on while external select bit low
`default_nettype none
package dosc_pkg;
  localparam int PCLK_NS = 4;
  // Serial register addresses
  localparam logic [4:0] ADDR_MAIN   = 5'h00;
  localparam logic [4:0] ADDR_SLEEP  = 5'h01;
  localparam logic [4:0] ADDR_GAIN   = 5'h04;
  localparam logic [4:0] ADDR_TEMP   = 5'h05;
  localparam logic [4:0] ADDR_DIVSYN = 5'h12;
  localparam logic [4:0] ADDR_OFS_AL = 5'h14;
  localparam logic [4:0] ADDR_OFS_AH = 5'h15;
  localparam logic [4:0] ADDR_OFS_BL = 5'h16;
  localparam logic [4:0] ADDR_OFS_BH = 5'h17;
  localparam logic [4:0] ADDR_TCTRL  = 5'h18;
  localparam logic [4:0] ADDR_REFCTL = 5'h19;
  // Field positions
  localparam int MAIN_FIFO_RST_BIT = 5;
  localparam int MAIN_MSYNC_BIT    = 4;
  localparam int DIVSYN_BIT        = 1;
  localparam int TSENSE_BIT        = 0;
  localparam int EXTREF_BIT        = 0;
  localparam int SLP_DAC_A = 0;
  localparam int SLP_DAC_B = 1;
  localparam int SLP_CLK_A = 2;
  localparam int SLP_CLK_B = 3;
  localparam int SLP_RECV  = 4;
  localparam int RD_BIT    = 7;
  // Reset values
  localparam logic [7:0] MAIN_RST   = 8'h30;
  localparam logic [7:0] DIVSYN_RST = 8'h02;
  localparam logic [7:0] GAIN_RST   = 8'hFF;
  localparam logic [7:0] ZERO_RST   = 8'h00;
  // Timing
  localparam int SLEEP_NS     = 90000;
  localparam int RESET_MIN_NS = 25;
  localparam int RESET_CYC    = (RESET_MIN_NS + PCLK_NS - 1) / PCLK_NS;
  localparam int TEMP_SCLK_NS = 1000;
  localparam int TEMP_HALF_CYC = (TEMP_SCLK_NS / 2 + PCLK_NS - 1) / PCLK_NS;
  localparam int FAST_HALF_CYC = 6;
  // Host APB map
  localparam logic [11:0] APB_CMD  = 12'h000;
  localparam logic [11:0] APB_STAT = 12'h004;
  localparam logic [11:0] APB_CTRL = 12'h008;
  typedef enum logic {DOSC_IDLE, DOSC_BUSY} dosc_hstate_t;
endpackage
`default_nettype wire

// ---- include/dosc_if.sv ----
// Serial control link between host controller and converter device.
// The data line has a pull-down; both ends drive only with enable high.
`timescale 1ns/10ps
`default_nettype none
interface dosc_if;
  logic serial_select_n;
  logic sclk;
  logic host_sdo;
  logic host_sdo_oe;
  logic dev_sdo;
  logic dev_sdo_oe;
  logic reset_n_pin;
  logic transmit_enable_pin;
  wire  sdio;
  assign sdio = dev_sdo_oe ? dev_sdo : (host_sdo_oe ? host_sdo : 1'b0);
  modport host_mp (output serial_select_n, sclk, host_sdo, host_sdo_oe, reset_n_pin,
                   transmit_enable_pin, input sdio);
  modport dev_mp (input serial_select_n, sclk, sdio, reset_n_pin, transmit_enable_pin,
                  output dev_sdo, dev_sdo_oe);
endinterface
`default_nettype wire

// ---- design/dosc_host.sv ----
// Host controller end: APB slave that issues serial register accesses,
// drives the reset and transmit enable pins.
// Assumes frame_in is on pclk; the link clock is made here by division.
`timescale 1ns/10ps
`default_nettype none
module dosc_host import dosc_pkg::*; #(
  parameter int FAST_HALF = FAST_HALF_CYC,
  parameter int SLOW_HALF = TEMP_HALF_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Data source frame marker
  input  wire logic        frame_in,
  // Link
  dosc_if.host_mp          link
);
  dosc_hstate_t st_reg;
  logic        acc;
  logic        cmd_pend_reg, auto_pend_reg, frame_d_reg;
  logic [15:0] cmd_reg, sh_reg;
  logic [7:0]  half_reg;
  logic [5:0]  ph_reg;
  logic        slow_reg, csn_reg, sclk_reg, oe_reg, rd_reg, txe_reg;
  logic [7:0]  rdata_reg, rst_cnt_reg;
  logic        start, use_cmd, half_done;

  assign acc     = psel & penable;
  assign pready  = 1'b1;
  assign pslverr = psel && !(paddr == APB_CMD || paddr == APB_STAT || paddr == APB_CTRL);
  assign start   = st_reg == DOSC_IDLE && (cmd_pend_reg || auto_pend_reg);
  assign use_cmd = cmd_pend_reg;
  assign half_done = half_reg == 8'((slow_reg ? SLOW_HALF : FAST_HALF) - 1);

  always_comb begin
    prdata = 32'h0;
    if (psel && !pwrite) begin
      unique case (paddr)
        APB_STAT: prdata = {21'h0, rst_cnt_reg != 8'h0, auto_pend_reg,
                            st_reg == DOSC_BUSY || cmd_pend_reg, rdata_reg};
        APB_CTRL: prdata = {31'h0, txe_reg};
        default:  prdata = 32'h0;
      endcase
    end
  end

  // Commands queue; a write while one waits or runs is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_pend_reg <= 1'b0;
      cmd_reg      <= 16'h0;
    end else if (acc && pwrite && paddr == APB_CMD && !cmd_pend_reg && st_reg == DOSC_IDLE) begin
      cmd_pend_reg <= 1'b1;
      cmd_reg      <= {pwdata[15], 2'b00, pwdata[12:0]};
    end else if (start && use_cmd) begin
      cmd_pend_reg <= 1'b0;
    end
  end

  // Frame rise queues clearing of divider sync; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_d_reg   <= 1'b0;
      auto_pend_reg <= 1'b0;
    end else begin
      frame_d_reg <= frame_in;
      if (frame_in && !frame_d_reg) begin
        auto_pend_reg <= 1'b1;
      end else if (start && !use_cmd) begin
        auto_pend_reg <= 1'b0;
      end
    end
  end

  // Pin sequencing: transmit held low until software raises it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txe_reg     <= 1'b0;
      rst_cnt_reg <= 8'h0;
    end else begin
      if (acc && pwrite && paddr == APB_CTRL) begin
        txe_reg <= pwdata[0];
      end
      if (acc && pwrite && paddr == APB_CTRL && pwdata[1]) begin
        rst_cnt_reg <= 8'(RESET_CYC);
      end else if (rst_cnt_reg != 8'h0) begin
        rst_cnt_reg <= rst_cnt_reg - 8'h1;
      end
    end
  end

  // Serial shifter: host drives on falls, samples on falls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg    <= DOSC_IDLE;
      sh_reg    <= 16'h0;
      half_reg  <= 8'h0;
      ph_reg    <= 6'h0;
      slow_reg  <= 1'b0;
      csn_reg   <= 1'b1;
      sclk_reg  <= 1'b0;
      oe_reg    <= 1'b0;
      rd_reg    <= 1'b0;
      rdata_reg <= 8'h0;
    end else if (start) begin
      st_reg   <= DOSC_BUSY;
      sh_reg   <= use_cmd ? cmd_reg : {3'b000, ADDR_DIVSYN, 8'h00};
      rd_reg   <= use_cmd & cmd_reg[15];
      slow_reg <= use_cmd && cmd_reg[15] && cmd_reg[12:8] == ADDR_TEMP;
      half_reg <= 8'h0;
      ph_reg   <= 6'h0;
      csn_reg  <= 1'b0;
      oe_reg   <= 1'b1;
    end else if (st_reg == DOSC_BUSY) begin
      if (!half_done) begin
        half_reg <= half_reg + 8'h1;
      end else begin
        half_reg <= 8'h0;
        ph_reg   <= ph_reg + 6'h1;
        if (ph_reg == 6'd32) begin
          csn_reg   <= 1'b1;
          oe_reg    <= 1'b0;
          st_reg    <= DOSC_IDLE;
          rdata_reg <= rd_reg ? sh_reg[7:0] : rdata_reg;
        end else if (!ph_reg[0]) begin
          sclk_reg <= 1'b1;
        end else begin
          sclk_reg <= 1'b0;
          sh_reg   <= {sh_reg[14:0], link.sdio};
          if (ph_reg == 6'd15 && rd_reg) begin
            oe_reg <= 1'b0;
          end
        end
      end
    end
  end

  assign link.serial_select_n     = csn_reg;
  assign link.sclk                = sclk_reg;
  assign link.host_sdo            = sh_reg[15];
  assign link.host_sdo_oe         = oe_reg;
  assign link.reset_n_pin         = rst_cnt_reg == 8'h0;
  assign link.transmit_enable_pin = txe_reg;
endmodule
`default_nettype wire

// ---- verification/dosc_properties.sv ----
// Link property checker for the converter control serial interface.
// Assumes pclk samples every link signal; sits beside the interface.
`timescale 1ns/10ps
`default_nettype none
module dosc_properties (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link signals
  input wire logic serial_select_n,
  input wire logic sclk,
  input wire logic host_sdo,
  input wire logic host_sdo_oe,
  input wire logic dev_sdo,
  input wire logic dev_sdo_oe,
  input wire logic reset_n_pin,
  input wire logic transmit_enable_pin
);
  logic       sclk_q;
  logic [5:0] rises;

  // Serial clock rises seen in the current frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q <= 1'b0;
      rises  <= 6'h00;
    end else begin
      sclk_q <= sclk;
      if (serial_select_n) begin
        rises <= 6'h00;
      end else if (sclk && !sclk_q) begin
        rises <= rises + 6'h01;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_idle_clock_low:
    assert property (serial_select_n && $past(serial_select_n) |-> !sclk)
    else $error("Serial clock moved outside a frame");
  a_frame_length:
    assert property ($rose(serial_select_n) |-> rises == 6'h10)
    else $error("Frame did not carry sixteen clocks");
  a_single_driver:
    assert property (!(dev_sdo_oe && host_sdo_oe))
    else $error("Both ends drive the data line");
  a_result_after_eight:
    assert property ($rose(dev_sdo_oe) |-> rises >= 6'h09)
    else $error("Device drove data before the ninth clock");
  a_release_after_frame:
    assert property ($rose(serial_select_n) |-> ##[0:6] !dev_sdo_oe)
    else $error("Device kept driving after the frame");
  a_clock_high_time:
    assert property ($rose(sclk) |-> sclk[*6])
    else $error("Serial clock high phase too short");
  a_clock_low_time:
    assert property ($fell(sclk) && !serial_select_n |-> !sclk[*6])
    else $error("Serial clock low phase too short");
  a_reset_pulse_width:
    assert property ($fell(reset_n_pin) |-> !reset_n_pin[*7])
    else $error("Device reset pulse too short");
  a_host_data_hold:
    assert property (sclk && $past(sclk) && host_sdo_oe |-> $stable(host_sdo))
    else $error("Host data changed while clock high");

  c_device_read: cover property ($rose(dev_sdo_oe));
  c_reset_pulse: cover property ($fell(reset_n_pin));
  c_tx_enable:   cover property ($rose(transmit_enable_pin));
endmodule
`default_nettype wire

// ---- verification/dosc_bench.sv ----
// Self-checking bench joining host and device ends over the serial link.
// Assumes 250 MHz pclk; APB drives the host, the device sees live samples.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("FAIL %s expected %0h seen %0h", nm, e, g); end end
module dosc_bench import dosc_pkg::*; ;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, frame_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic signed [15:0] sample_a, sample_b, data_a, data_b;
  logic signed [9:0] temp_raw;
  logic [4:0] fs_scale_a, fs_scale_b;
  logic bandgap_on, dac_asleep_a, dac_asleep_b, clkpath_sleep_a, clkpath_sleep_b;
  logic clkrecv_sleep, fifo_reset_ena, multi_sync_ena, clkdiv_sync_ena, tx_active, e;
  logic [7:0] q;
  int fails, compares, cycles;

  dosc_if lnk ();
  dosc_host u_dosc_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_in(frame_in), .link(lnk));
  // Short sleep count keeps the run brief
  dosc_device #(.SLEEP_CYC(20)) u_dosc_device (.pclk(pclk), .presetn(presetn),
    .link(lnk), .sample_a(sample_a), .sample_b(sample_b), .data_a(data_a),
    .data_b(data_b), .temp_raw(temp_raw), .fs_scale_a(fs_scale_a),
    .fs_scale_b(fs_scale_b), .bandgap_on(bandgap_on), .dac_asleep_a(dac_asleep_a),
    .dac_asleep_b(dac_asleep_b), .clkpath_sleep_a(clkpath_sleep_a),
    .clkpath_sleep_b(clkpath_sleep_b), .clkrecv_sleep(clkrecv_sleep),
    .fifo_reset_ena(fifo_reset_ena), .multi_sync_ena(multi_sync_ena),
    .clkdiv_sync_ena(clkdiv_sync_ena), .tx_active(tx_active));
  dosc_properties u_dosc_properties (.pclk(pclk), .presetn(presetn),
    .serial_select_n(lnk.serial_select_n), .sclk(lnk.sclk), .host_sdo(lnk.host_sdo),
    .host_sdo_oe(lnk.host_sdo_oe), .dev_sdo(lnk.dev_sdo), .dev_sdo_oe(lnk.dev_sdo_oe),
    .reset_n_pin(lnk.reset_n_pin), .transmit_enable_pin(lnk.transmit_enable_pin));

  always #2 pclk = ~pclk;

  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Temperature reads at 1 us clocks dominate the run
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      test_done;
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Waits out busy, queued clear and reset pulse
  task automatic sif_wait;
    do apb(1'b0, APB_STAT, 32'h0); while (r[10:8] !== 3'b000);
  endtask

  task automatic serial_control_interface(input logic rd, input logic [4:0] a, input logic [7:0] d);
    apb(1'b1, APB_CMD, {16'h0000, rd, 2'b00, a, d});
    sif_wait;
    q = r[7:0];
  endtask

  task automatic t_reset_values;
    serial_control_interface(1'b1, ADDR_MAIN, 8'h00);
    `CHK("main", 8'h30, q)
    serial_control_interface(1'b1, ADDR_GAIN, 8'h00);
    `CHK("gain", 8'hFF, q)
    `CHK("scale_a", 5'h10, fs_scale_a)
    `CHK("bandgap", 1'b1, bandgap_on)
    `CHK("divsync", 1'b1, clkdiv_sync_ena)
    serial_control_interface(1'b1, 5'h1F, 8'h00);
    `CHK("unmapped", 8'h00, q)
    apb(1'b0, 12'h00C, 32'h0);
    `CHK("pslverr", 1'b1, e)
  endtask

  task automatic t_offset;
    sample_a <= 16'sh0064;
    sample_b <= 16'shFFCE;
    serial_control_interface(1'b0, ADDR_OFS_AH, 8'h10);
    serial_control_interface(1'b0, ADDR_OFS_BL, 8'hFF);
    serial_control_interface(1'b0, ADDR_OFS_BH, 8'h0F);
    repeat (8) @(posedge pclk);
    `CHK("staged_a", 16'h0064, data_a)
    `CHK("staged_b", 16'hFFCE, data_b)
    serial_control_interface(1'b0, ADDR_OFS_AL, 8'h00);
    repeat (8) @(posedge pclk);
    `CHK("sum_a", 16'hF064, data_a)
    `CHK("sum_b", 16'h0FCD, data_b)
    sample_a <= 16'sh800A;
    sample_b <= 16'sh7FFA;
    repeat (3) @(posedge pclk);
    `CHK("clip_a", 16'h8000, data_a)
    `CHK("clip_b", 16'h7FFF, data_b)
  endtask

  task automatic t_temp;
    serial_control_interface(1'b0, ADDR_TCTRL, 8'h01);
    temp_raw <= 10'sh032;
    serial_control_interface(1'b1, ADDR_TEMP, 8'h00);
    `CHK("temp", 8'h19, q)
    temp_raw <= 10'sh270;
    serial_control_interface(1'b1, ADDR_TEMP, 8'h00);
    `CHK("temp_low", 8'h80, q)
    temp_raw <= 10'sh12C;
    serial_control_interface(1'b1, ADDR_TEMP, 8'h00);
    `CHK("temp_high", 8'h7F, q)
    serial_control_interface(1'b0, ADDR_TCTRL, 8'h00);
    temp_raw <= 10'sh028;
    serial_control_interface(1'b1, ADDR_TEMP, 8'h00);
    `CHK("temp_kept", 8'h7F, q)
  endtask

  task automatic t_sleep;
    serial_control_interface(1'b0, ADDR_SLEEP, 8'h1F);
    `CHK("dac_a_early", 1'b0, dac_asleep_a)
    repeat (4) @(posedge pclk);
    `CHK("clk_a", 1'b1, clkpath_sleep_a)
    `CHK("clk_b", 1'b1, clkpath_sleep_b)
    `CHK("recv", 1'b1, clkrecv_sleep)
    repeat (30) @(posedge pclk);
    `CHK("dac_a", 1'b1, dac_asleep_a)
    `CHK("dac_b", 1'b1, dac_asleep_b)
    temp_raw <= 10'sh01E;
    serial_control_interface(1'b0, ADDR_TCTRL, 8'h01);
    serial_control_interface(1'b1, ADDR_TEMP, 8'h00);
    `CHK("temp_asleep", 8'h0F, q)
    temp_raw <= 10'sh014;
    serial_control_interface(1'b0, ADDR_TCTRL, 8'h00);
    serial_control_interface(1'b1, ADDR_TEMP, 8'h00);
    `CHK("temp_on_write", 8'h0A, q)
    serial_control_interface(1'b0, ADDR_SLEEP, 8'h00);
    `CHK("wake_early", 1'b1, dac_asleep_b)
    repeat (30) @(posedge pclk);
    `CHK("wake", 1'b0, dac_asleep_b)
  endtask

  task automatic t_frame;
    frame_in <= 1'b1;
    repeat (4) @(posedge pclk);
    sif_wait;
    serial_control_interface(1'b1, ADDR_DIVSYN, 8'h00);
    `CHK("divsync_reg", 8'h00, q)
    `CHK("divsync_out", 1'b0, clkdiv_sync_ena)
    serial_control_interface(1'b0, ADDR_MAIN, 8'h00);
    repeat (4) @(posedge pclk);
    `CHK("fifo_rst", 1'b0, fifo_reset_ena)
    `CHK("msync", 1'b0, multi_sync_ena)
  endtask

  task automatic t_ctrl;
    serial_control_interface(1'b0, ADDR_GAIN, 8'h3A);
    repeat (4) @(posedge pclk);
    `CHK("scale_a", 5'h04, fs_scale_a)
    `CHK("scale_b", 5'h0B, fs_scale_b)
    serial_control_interface(1'b0, ADDR_REFCTL, 8'h01);
    repeat (4) @(posedge pclk);
    `CHK("extref", 1'b0, bandgap_on)
    apb(1'b1, APB_CTRL, 32'h0000_0001);
    apb(1'b0, APB_CTRL, 32'h0);
    `CHK("ctrl", 1'b1, r[0])
    repeat (8) @(posedge pclk);
    `CHK("txen", 1'b1, tx_active)
    apb(1'b1, APB_CTRL, 32'h0000_0003);
    sif_wait;
    repeat (8) @(posedge pclk);
    `CHK("soft_rst", 5'h10, fs_scale_a)
    `CHK("soft_ref", 1'b1, bandgap_on)
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    frame_in = 1'b0;
    sample_a = 16'sh0000;
    sample_b = 16'sh0000;
    temp_raw = 10'sh000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values;
    t_offset;
    t_temp;
    t_sleep;
    t_frame;
    t_ctrl;
    test_done;
  end
endmodule
`default_nettype wire
